//--- flash_prog_pkg.sv
`default_nettype none

package flash_prog_pkg;

	// Clock period of core_clk.
	localparam int unsigned CLK_PERIOD_NS     = 50;

	// Pin timing of the memory, in the units in which it is specified.
	localparam int unsigned WRITE_PULSE_NS    = 35;
	localparam int unsigned READ_ACCESS_NS    = 90;
	localparam int unsigned BUS_RELEASE_NS    = 25;
	localparam int unsigned RESET_PULSE_NS    = 500;
	localparam int unsigned RESET_HIGH_NS     = 100;
	localparam int unsigned POLL_DELAY_US     = 4;
	localparam int unsigned PROGRAM_MAX_US    = 1000;

	// Least times round up to whole cycles and never fall below one.
	function automatic int unsigned ns_to_cycles(input int unsigned ns);
		int unsigned c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c == 0) ? 1 : c;
	endfunction : ns_to_cycles

	localparam int unsigned WRITE_PULSE_CYCLES = ns_to_cycles(WRITE_PULSE_NS);
	localparam int unsigned READ_ACCESS_CYCLES = ns_to_cycles(READ_ACCESS_NS);
	localparam int unsigned BUS_RELEASE_CYCLES = ns_to_cycles(BUS_RELEASE_NS);
	localparam int unsigned RESET_PULSE_CYCLES = ns_to_cycles(RESET_PULSE_NS);
	localparam int unsigned RESET_HIGH_CYCLES  = ns_to_cycles(RESET_HIGH_NS);
	localparam int unsigned POLL_DELAY_CYCLES  =
		ns_to_cycles(POLL_DELAY_US * 1000);
	localparam int unsigned PROGRAM_TIMEOUT_CYCLES =
		ns_to_cycles(PROGRAM_MAX_US * 1000);

	// Word mode command addresses and the command codes.
	localparam logic [11:0] WORD_UNLOCK_ADDR1 = 12'h555;
	localparam logic [11:0] WORD_UNLOCK_ADDR2 = 12'h2aa;
	localparam logic [7:0]  UNLOCK_CODE1      = 8'haa;
	localparam logic [7:0]  UNLOCK_CODE2      = 8'h55;
	localparam logic [7:0]  PROGRAM_CODE      = 8'ha0;
	localparam logic [1:0]  LAST_CMD_STEP     = 2'h3;
	localparam int unsigned STATUS_BIT        = 7;

	typedef enum {
		E_IDLE,
		E_SETUP,
		E_STROBE,
		E_HOLD,
		E_GAP
	} engine_state_t;

	typedef enum {
		M_RST_LOW,
		M_RST_HIGH,
		M_IDLE,
		M_FETCH,
		M_CMD,
		M_WAIT,
		M_POLL,
		M_VERIFY
	} seq_state_t;

endpackage : flash_prog_pkg

`default_nettype wire

//--- flash_cycle_if.sv
`default_nettype none

interface flash_cycle_if #(
	parameter int ADDR_W = 20,
	parameter int DATA_W = 16
);
	logic              req;
	logic              write;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              ack;
	logic [DATA_W-1:0] rdata;

	modport sequencer (output req, write, addr, wdata, input ack, rdata);
	modport engine    (input req, write, addr, wdata, output ack, rdata);
endinterface : flash_cycle_if

`default_nettype wire

//--- flash_bus_engine.sv
`default_nettype none

module flash_bus_engine #(
	parameter int ADDR_W = 20,
	parameter int DATA_W = 16
) (
	input  wire logic              core_clk,
	input  wire logic              reset_n,
	flash_cycle_if.engine          cyc,
	output logic [ADDR_W-1:0]      flash_addr,
	output logic [DATA_W-1:0]      flash_dq_out,
	input  wire logic [DATA_W-1:0] flash_dq_in,
	output logic                   flash_dq_oe_n,
	output logic                   flash_ce_n,
	output logic                   flash_we_n,
	output logic                   flash_oe_n
);
	import flash_prog_pkg::*;

	engine_state_t state;
	logic [3:0]    cnt;
	logic          is_write;
	logic [DATA_W-1:0] rdata;

	////////////////////////////////////////////////////////////////////////
	// The request is taken only in E_IDLE, so a request still held in the
	// acknowledge cycle cannot start a second bus cycle by accident.
	assign cyc.ack   = (state == E_GAP) && (cnt == 4'h0);
	assign cyc.rdata = rdata;

	////////////////////////////////////////////////////////////////////////
	// One bus cycle: chip select, strobe, release, then a quiet gap so the
	// memory has let go of the data bus before anything else is driven.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state         <= E_IDLE;
			cnt           <= 4'h0;
			is_write      <= 1'b0;
			rdata         <= '0;
			flash_addr    <= '0;
			flash_dq_out  <= '0;
			flash_dq_oe_n <= 1'b1;
			flash_ce_n    <= 1'b1;
			flash_we_n    <= 1'b1;
			flash_oe_n    <= 1'b1;
		end else begin
			case (state)
				E_IDLE: begin
					if (cyc.req) begin
						flash_addr    <= cyc.addr;
						flash_dq_out  <= cyc.wdata;
						is_write      <= cyc.write;
						flash_dq_oe_n <= ~cyc.write;
						flash_ce_n    <= 1'b0;
						state         <= E_SETUP;
					end
				end
				E_SETUP: begin
					flash_we_n <= ~is_write;
					flash_oe_n <= is_write;
					cnt        <= is_write ? 4'(WRITE_PULSE_CYCLES - 1)
					                       : 4'(READ_ACCESS_CYCLES - 1);
					state      <= E_STROBE;
				end
				E_STROBE: begin
					if (cnt == 4'h0) begin
						flash_we_n <= 1'b1;
						flash_oe_n <= 1'b1;
						if (!is_write) begin
							rdata <= flash_dq_in;
						end
						state <= E_HOLD;
					end else begin
						cnt <= cnt - 4'h1;
					end
				end
				E_HOLD: begin
					flash_ce_n    <= 1'b1;
					flash_dq_oe_n <= 1'b1;
					cnt           <= 4'(BUS_RELEASE_CYCLES - 1);
					state         <= E_GAP;
				end
				E_GAP: begin
					if (cnt == 4'h0) begin
						state <= E_IDLE;
					end else begin
						cnt <= cnt - 4'h1;
					end
				end
				default: begin
					state <= E_IDLE;
				end
			endcase
		end
	end

endmodule : flash_bus_engine

`default_nettype wire

//--- flash_word_program_sequence.sv
`default_nettype none

// Summary of operation
// - Each word takes unlock, unlock, program command, then value at target.
// - Status polling starts no sooner than 4 us after the command.
// - Poll to completion, verify, then advance address or finish.
// - Word mode and byte mode use different command addresses.
module flash_word_program_sequence #(
	parameter int          ADDR_W = 20,
	parameter int          DATA_W = 16,
	parameter int unsigned TIMEOUT_CYCLES =
		flash_prog_pkg::PROGRAM_TIMEOUT_CYCLES,
	parameter logic [11:0] BYTE_UNLOCK_ADDR1 = 12'haaa,
	parameter logic [11:0] BYTE_UNLOCK_ADDR2 = 12'h555
) (
	input  wire logic              core_clk,
	input  wire logic              reset_n,
	input  wire logic              start,
	input  wire logic [ADDR_W-1:0] start_addr,
	input  wire logic [ADDR_W-1:0] last_addr,
	input  wire logic              byte_mode,
	input  wire logic              value_valid,
	input  wire logic [DATA_W-1:0] program_value,
	output logic                   value_ready,
	output logic                   busy,
	output logic                   done,
	output logic                   fail,
	output logic [ADDR_W-1:0]      flash_addr,
	output logic [DATA_W-1:0]      flash_dq_out,
	input  wire logic [DATA_W-1:0] flash_dq_in,
	output logic                   flash_dq_oe_n,
	output logic                   flash_ce_n,
	output logic                   flash_we_n,
	output logic                   flash_oe_n,
	output logic                   flash_reset_n
);
	import flash_prog_pkg::*;

	seq_state_t        state;
	logic [15:0]       cnt;
	logic [31:0]       tmo;
	logic [1:0]        step;
	logic [ADDR_W-1:0] target;
	logic [ADDR_W-1:0] last;
	logic [DATA_W-1:0] value_q;

	flash_cycle_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) cyc ();

	////////////////////////////////////////////////////////////////////////
	// Address of each of the four command cycles; the fourth goes to the
	// word being programmed.
	function automatic logic [ADDR_W-1:0] cmd_addr(
		input logic [1:0]        s,
		input logic              bmode,
		input logic [ADDR_W-1:0] tgt
	);
		logic [11:0] a1;
		logic [11:0] a2;
		a1 = bmode ? BYTE_UNLOCK_ADDR1 : WORD_UNLOCK_ADDR1;
		a2 = bmode ? BYTE_UNLOCK_ADDR2 : WORD_UNLOCK_ADDR2;
		case (s)
			2'h0:    return ADDR_W'(a1);
			2'h1:    return ADDR_W'(a2);
			2'h2:    return ADDR_W'(a1);
			default: return tgt;
		endcase
	endfunction : cmd_addr

	// Data of each command cycle.
	function automatic logic [DATA_W-1:0] cmd_data(
		input logic [1:0]        s,
		input logic [DATA_W-1:0] val
	);
		case (s)
			2'h0:    return DATA_W'(UNLOCK_CODE1);
			2'h1:    return DATA_W'(UNLOCK_CODE2);
			2'h2:    return DATA_W'(PROGRAM_CODE);
			default: return val;
		endcase
	endfunction : cmd_data

	////////////////////////////////////////////////////////////////////////
	// Bus requests are decoded from the state; writes only while issuing
	// commands, reads of the target while polling and verifying.
	wire issuing   = (state == M_CMD);
	wire reading   = (state == M_POLL) || (state == M_VERIFY);
	wire status_ok = cyc.rdata[STATUS_BIT] == value_q[STATUS_BIT];
	wire word_ok   = cyc.rdata == value_q;
	wire at_last   = target == last;
	wire timed_out = tmo >= TIMEOUT_CYCLES - 1;

	assign cyc.req     = issuing || reading;
	assign cyc.write   = issuing;
	assign cyc.addr    = issuing ? cmd_addr(step, byte_mode, target)
	                             : target;
	assign cyc.wdata   = cmd_data(step, value_q);
	assign value_ready = (state == M_FETCH);

	flash_bus_engine #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_engine (
		.core_clk      (core_clk),
		.reset_n       (reset_n),
		.cyc           (cyc),
		.flash_addr    (flash_addr),
		.flash_dq_out  (flash_dq_out),
		.flash_dq_in   (flash_dq_in),
		.flash_dq_oe_n (flash_dq_oe_n),
		.flash_ce_n    (flash_ce_n),
		.flash_we_n    (flash_we_n),
		.flash_oe_n    (flash_oe_n)
	);

	////////////////////////////////////////////////////////////////////////
	// Sequencer. The memory is held in reset after our own reset so both
	// start from a known point, then released for its recovery time.
	// No read-mode command is ever sent after programming, since the
	// memory goes back to read mode on its own.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state         <= M_RST_LOW;
			cnt           <= 16'h0000;
			tmo           <= 32'h0000_0000;
			step          <= 2'h0;
			target        <= '0;
			last          <= '0;
			value_q       <= '0;
			busy          <= 1'b0;
			done          <= 1'b0;
			fail          <= 1'b0;
			flash_reset_n <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
				M_RST_LOW: begin
					if (cnt == 16'(RESET_PULSE_CYCLES - 1)) begin
						flash_reset_n <= 1'b1;
						cnt           <= 16'h0000;
						state         <= M_RST_HIGH;
					end else begin
						cnt <= cnt + 16'h0001;
					end
				end
				M_RST_HIGH: begin
					if (cnt == 16'(RESET_HIGH_CYCLES - 1)) begin
						cnt   <= 16'h0000;
						state <= M_IDLE;
					end else begin
						cnt <= cnt + 16'h0001;
					end
				end
				M_IDLE: begin
					if (start) begin
						target <= start_addr;
						last   <= last_addr;
						busy   <= 1'b1;
						fail   <= 1'b0;
						state  <= M_FETCH;
					end
				end
				M_FETCH: begin
					if (value_valid) begin
						value_q <= program_value;
						step    <= 2'h0;
						state   <= M_CMD;
					end
				end
				M_CMD: begin
					if (cyc.ack) begin
						if (step == LAST_CMD_STEP) begin
							cnt   <= 16'h0000;
							tmo   <= 32'h0000_0000;
							state <= M_WAIT;
						end else begin
							step <= step + 2'h1;
						end
					end
				end
				M_WAIT: begin
					tmo <= tmo + 32'h0000_0001;
					if (cnt == 16'(POLL_DELAY_CYCLES - 1)) begin
						state <= M_POLL;
					end else begin
						cnt <= cnt + 16'h0001;
					end
				end
				M_POLL: begin
					tmo <= tmo + 32'h0000_0001;
					if (cyc.ack) begin
						if (status_ok) begin
							state <= M_VERIFY;
						end else if (timed_out) begin
							fail  <= 1'b1;
							busy  <= 1'b0;
							done  <= 1'b1;
							state <= M_IDLE;
						end
					end
				end
				M_VERIFY: begin
					if (cyc.ack) begin
						if (!word_ok || at_last) begin
							fail  <= !word_ok;
							busy  <= 1'b0;
							done  <= 1'b1;
							state <= M_IDLE;
						end else begin
							target <= target + ADDR_W'(1);
							state  <= M_FETCH;
						end
					end
				end
				default: begin
					state <= M_IDLE;
				end
			endcase
		end
	end

endmodule : flash_word_program_sequence

`default_nettype wire

//--- flash_prog_monitor.sv
`default_nettype none

// Watches the memory pins and the user handshake of the sequencer.
module flash_prog_monitor
	import flash_prog_pkg::*;
#(
	parameter int ADDR_W = 20,
	parameter int DATA_W = 16
) (
	input wire logic              core_clk,
	input wire logic              reset_n,
	input wire logic              start,
	input wire logic              value_ready,
	input wire logic              busy,
	input wire logic              done,
	input wire logic [ADDR_W-1:0] flash_addr,
	input wire logic [DATA_W-1:0] flash_dq_out,
	input wire logic              flash_dq_oe_n,
	input wire logic              flash_ce_n,
	input wire logic              flash_we_n,
	input wire logic              flash_oe_n,
	input wire logic              flash_reset_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] since_wr;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	// Cycles since the last write strobe ended; saturates so it never wraps.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			since_wr <= 8'hff;
		else if ($rose(flash_we_n))
			since_wr <= 8'h00;
		else if (since_wr != 8'hff)
			since_wr <= since_wr + 8'h01;
	end

	////////////////////////////////////////////////////////////////////////
	property p_we_framed;
		!flash_we_n |-> !flash_ce_n && !flash_dq_oe_n && flash_oe_n;
	endproperty
	a_we_framed: assert property (p_we_framed)
		else $error("write strobe outside a driven cycle");
	property p_we_width;
		$fell(flash_we_n) |=> flash_we_n;
	endproperty
	a_we_width: assert property (p_we_width)
		else $error("write strobe not one cycle");
	property p_we_stable;
		!flash_we_n |-> $stable(flash_addr) && $stable(flash_dq_out);
	endproperty
	a_we_stable: assert property (p_we_stable)
		else $error("address or data moved under write strobe");
	property p_read_clean;
		!flash_oe_n |-> flash_dq_oe_n && flash_we_n && !flash_ce_n;
	endproperty
	a_read_clean: assert property (p_read_clean)
		else $error("read while host drives the bus");
	property p_poll_wait;
		$fell(flash_oe_n) |-> since_wr >= POLL_DELAY_CYCLES;
	endproperty
	a_poll_wait: assert property (p_poll_wait)
		else $error("status read too soon after command");
	property p_oe_width;
		$fell(flash_oe_n) |=> !flash_oe_n ##1 flash_oe_n;
	endproperty
	a_oe_width: assert property (p_oe_width)
		else $error("read strobe not two cycles");
	property p_done_pulse;
		done |-> $past(busy) && !busy ##1 !done;
	endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("done not a single pulse ending busy");
	property p_ready_idle;
		value_ready |-> busy && flash_ce_n;
	endproperty
	a_ready_idle: assert property (p_ready_idle)
		else $error("value request outside a quiet run");
	property p_busy_start;
		$rose(busy) |-> $past(start);
	endproperty
	a_busy_start: assert property (p_busy_start)
		else $error("run began without start");
	// A command cycle sent into a memory still held in reset would be lost.
	property p_reset_quiet;
		!flash_reset_n |-> flash_ce_n && flash_we_n && flash_oe_n;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("bus cycle while memory held in reset");
endmodule : flash_prog_monitor

bind flash_word_program_sequence flash_prog_monitor #(
	.ADDR_W(ADDR_W),
	.DATA_W(DATA_W)
) u_mon (
	.core_clk, .reset_n, .start, .value_ready, .busy, .done, .flash_addr,
	.flash_dq_out, .flash_dq_oe_n, .flash_ce_n, .flash_we_n, .flash_oe_n,
	.flash_reset_n
);

`default_nettype wire

//--- flash_mem_model.sv
`default_nettype none

// Behavioural memory: takes the unlock and program sequence, then shows
// the inverted status bit until programming ends.
module flash_mem_model #(
	parameter logic [11:0] BA1 = 12'haaa,
	parameter logic [11:0] BA2 = 12'h555
) (
	input  wire logic [19:0] addr,
	input  wire logic [15:0] dq_out,
	output logic      [15:0] dq_in,
	input  wire logic        ce_n,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	input  wire logic        rst_n,
	input  wire logic        byte_mode,
	input  wire logic        slow,
	input  wire logic        corrupt,
	output int               seq_err
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem[logic [19:0]];
	logic [15:0] pv, rd;
	logic [19:0] tgt, a1, a2;
	logic        prog;
	int          step;

	// Command addresses follow the bus width in use.
	assign a1 = byte_mode ? 20'(BA1) : 20'h555;
	assign a2 = byte_mode ? 20'(BA2) : 20'h2aa;

	initial begin
		seq_err = 0;
		step = 0;
		prog = 1'b0;
	end

	// Writes land on the rising strobe; while programming they are ignored.
	always @(posedge we_n or negedge rst_n) begin
		if (!rst_n)
			step = 0;
		else if (!ce_n && !prog) begin
			if (step == 3) begin
				tgt = addr;
				pv = corrupt ? dq_out ^ 16'h0001 : dq_out;
				prog = 1'b1;
				step = 0;
				fork
					begin
						#(slow ? 30000 : 6000);
						mem[tgt] = pv;
						prog = 1'b0;
					end
				join_none
			end else if ((step == 0 && addr == a1 && dq_out[7:0] == 8'haa) ||
				(step == 1 && addr == a2 && dq_out[7:0] == 8'h55) ||
				(step == 2 && addr == a1 && dq_out[7:0] == 8'ha0))
				step++;
			else begin
				seq_err++;
				step = 0;
			end
		end
	end

	// A released bus shows the inverse, so a stale sample cannot pass.
	always @* begin
		if (prog && addr == tgt)
			rd = {pv[15:8], ~pv[7], pv[6:0]};
		else if (mem.exists(addr))
			rd = mem[addr];
		else
			rd = 16'hffff;
		dq_in = (!ce_n && !oe_n) ? rd : ~rd;
	end
endmodule : flash_mem_model

`default_nettype wire

//--- tb.sv
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int AW = 20;
	localparam int DW = 16;
	logic          core_clk, reset_n, start, byte_mode, value_valid;
	logic          value_ready, busy, done, fail, flash_dq_oe_n;
	logic          flash_ce_n, flash_we_n, flash_oe_n, flash_reset_n;
	logic          slow, corrupt;
	logic [AW-1:0] start_addr, last_addr, flash_addr;
	logic [DW-1:0] program_value, flash_dq_out, flash_dq_in;
	logic          exp_q[$];
	logic [DW-1:0] shadow[logic [AW-1:0]];
	int            miscompares, checks, cycles, seq_err;

	flash_word_program_sequence #(.TIMEOUT_CYCLES(200)) dut (
		.core_clk, .reset_n, .start, .start_addr, .last_addr, .byte_mode,
		.value_valid, .program_value, .value_ready, .busy, .done, .fail,
		.flash_addr, .flash_dq_out, .flash_dq_in, .flash_dq_oe_n,
		.flash_ce_n, .flash_we_n, .flash_oe_n, .flash_reset_n
	);

	flash_mem_model u_mem (
		.addr(flash_addr), .dq_out(flash_dq_out), .dq_in(flash_dq_in),
		.ce_n(flash_ce_n), .we_n(flash_we_n), .oe_n(flash_oe_n),
		.rst_n(flash_reset_n), .byte_mode, .slow, .corrupt, .seq_err
	);

	////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic end_of_test();
		if (miscompares == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test

	// The watchdog sits well above the few thousand cycles the runs take.
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			$display("CHECK FAILED %0t run hung", $time);
			end_of_test();
		end
	end

	// Each done pulse is matched against the oldest noted outcome.
	always @(posedge core_clk) begin
		if (done === 1'b1) begin
			checks++;
			if (exp_q.size() == 0 || fail !== exp_q[0]) begin
				miscompares++;
				$display("CHECK FAILED %0t unexpected outcome", $time);
			end
			if (exp_q.size() != 0)
				void'(exp_q.pop_front());
		end
	end

	// One run of n words; poke raises start again while the run is busy.
	task automatic run(input logic [AW-1:0] base, input int n,
		input logic bm, input logic exp_fail, input logic poke);
		int w;
		start_addr = base;
		last_addr = base + AW'(n - 1);
		byte_mode = bm;
		start = 1'b1;
		@(posedge core_clk) #2 start = 1'b0;
		exp_q.push_back(exp_fail);
		for (int i = 0; i < n; i++) begin
			w = 0;
			while (value_ready !== 1'b1 && w < 2000) begin
				@(posedge core_clk) #2 w++;
			end
			// A limit that runs out is a failure, not a silent skip.
			if (w >= 2000) begin
				miscompares++;
				$display("CHECK FAILED %0t no value request", $time);
			end
			program_value = DW'($urandom);
			shadow[base + AW'(i)] = program_value;
			value_valid = 1'b1;
			@(posedge core_clk) #2 value_valid = 1'b0;
			if (poke) begin
				start = 1'b1;
				@(posedge core_clk) #2 start = 1'b0;
			end
		end
		w = 0;
		while (busy !== 1'b0 && w < 4000) begin
			@(posedge core_clk) #2 w++;
		end
		if (w >= 4000) begin
			miscompares++;
			$display("CHECK FAILED %0t run never ended", $time);
		end
		@(posedge core_clk) #2;
	endtask : run

	task automatic check_mem();
		foreach (shadow[a]) begin
			checks++;
			if (u_mem.mem[a] !== shadow[a]) begin
				miscompares++;
				$display("CHECK FAILED %0t word %h wrong", $time, a);
			end
		end
		shadow.delete();
	endtask : check_mem

	////////////////////////////////////////////////////////////////////////
	initial begin
		reset_n = 1'b0;
		{start, byte_mode, value_valid, slow, corrupt} = 5'h00;
		{start_addr, last_addr, program_value} = '0;
		{miscompares, checks, cycles} = 0;
		void'($urandom(32'h27ec70a6));
		repeat (8) @(posedge core_clk);
		#2 reset_n = 1'b1;
		repeat (14) @(posedge core_clk);
		#2;
		run({4'h1, 8'($urandom), 8'h00}, 4, 1'b0, 1'b0, 1'b0);
		check_mem();
		run({4'h2, 8'($urandom), 8'h00}, 2, 1'b1, 1'b0, 1'b0);
		check_mem();
		corrupt = 1'b1;
		run({4'h3, 8'($urandom), 8'h00}, 1, 1'b0, 1'b1, 1'b0);
		corrupt = 1'b0;
		slow = 1'b1;
		run({4'h4, 8'($urandom), 8'h00}, 1, 1'b0, 1'b1, 1'b0);
		slow = 1'b0;
		shadow.delete();
		repeat (700) @(posedge core_clk);
		#2;
		run({4'h5, 8'($urandom), 8'hfe}, 2, 1'b0, 1'b0, 1'b1);
		check_mem();
		checks++;
		if (seq_err !== 0 || exp_q.size() != 0) begin
			miscompares++;
			$display("CHECK FAILED %0t bad command order", $time);
		end
		end_of_test();
	end
endmodule : tb

`default_nettype wire
